// ---- rtl/tsw_device.sv ----
// Device end: two task status words and the unit error indication
`timescale 1ns/1ps
// Function
// R01 - Task error on program or axis fault
// R02 - Persistent fault sets error again on run
// R03 - Task error also sets unit error
// R04 - Task error held until host reset
// R05 - Unit error cleared by reset, set again
// R06 - Start ignored unless automatic mode shown
// R07 - Manual commands ignored unless manual shown
// R08 - Modes clear during 130 ms initialisation
// R09 - Auto to manual clears run flags
// R10 - Run held through M reset and stop
// R11 - Program end sets completed, clears run
// R12 - Completed cleared on start or manual
// R13 - Host releases start on completed
// R14 - Host times pause from run flag
// R15 - Optional stop waits input high then low
// R16 - Optional move waits input high
// R17 - Low M codes wait for reset pulse
// R18 - High M codes do not wait
// R19 - Run set while M reset pending
// R20 - Strobe set while any M code out
// R21 - Start received follows start edge, level
// R22 - Identical second word for task two
// R23 - Host holds start each phase 20 ms
// R24 - Flags clocked, presented every refresh
module tsw_device #(
  parameter int INIT_CYC = tsw_pkg::TSW_INIT_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Host side
  tsw_if.device LINK,
  // Execution events, one bit per task, and one M code per task
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] PROG_ERR_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] AXIS_ERR_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] END_INSTR_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] OPT_STOP_INSTR_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] OPT_MOVE_INSTR_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] OPT_INPUT_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] MCODE_VALID_I,
  input wire logic [tsw_pkg::TSW_MCODE_W-1:0] MCODE_ONE_I,
  input wire logic [tsw_pkg::TSW_MCODE_W-1:0] MCODE_TWO_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] DECEL_STOP_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] AXES_STOPPED_I,
  // Status
  output logic READY_O
);
  import tsw_pkg::*;

  typedef struct packed {
    logic [31:0] init_cnt;
    logic ready;
    logic unit_err;
  } tsw_dev_t;

  tsw_dev_t d_reg, d_next;
  logic [TSW_WORD_W-1:0] word [TSW_NUM_TASKS];
  logic [TSW_NUM_TASKS-1:0] err_set;
  logic [TSW_MCODE_W-1:0] mcode [TSW_NUM_TASKS];

  assign mcode[0] = MCODE_ONE_I;
  assign mcode[1] = MCODE_TWO_I;

  // ----------------------------------------
  // Per task words
  // ----------------------------------------
  for (genvar t = 0; t < TSW_NUM_TASKS; t++) begin : g_task
    tsw_task u_task (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .ready_i(d_reg.ready),
      .auto_req_i(LINK.auto_req[t]),
      .cycle_start_i(LINK.cycle_start[t]),
      .err_reset_i(LINK.err_reset[t]),
      .mcode_reset_i(LINK.mcode_reset[t]),
      .prog_err_i(PROG_ERR_I[t]),
      .axis_err_i(AXIS_ERR_I[t]),
      .end_instr_i(END_INSTR_I[t]),
      .opt_stop_instr_i(OPT_STOP_INSTR_I[t]),
      .opt_move_instr_i(OPT_MOVE_INSTR_I[t]),
      .opt_input_i(OPT_INPUT_I[t]),
      .mcode_valid_i(MCODE_VALID_I[t]),
      .mcode_i(mcode[t]),
      .decel_stop_i(DECEL_STOP_I[t]),
      .axes_stopped_i(AXES_STOPPED_I[t]),
      .word_o(word[t]),
      .err_set_o(err_set[t])
    );
  end

  // ----------------------------------------
  // Initialisation and unit error
  // ----------------------------------------
  always_comb begin
    d_next = d_reg;
    if (!d_reg.ready) begin
      // Commands held off until the count ends
      if (d_reg.init_cnt >= 32'(INIT_CYC - 1)) begin
        d_next.ready = 1'b1; // see R08
      end else begin
        d_next.init_cnt = d_reg.init_cnt + 32'h1;
      end
    end
    if (LINK.unit_err_reset) begin
      d_next.unit_err = 1'b0; // see R05
    end
    if (|err_set) begin
      d_next.unit_err = 1'b1; // see R03 R05
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  // Words come from task flip-flops, mapped to their own positions
  assign LINK.status_one = word[0]; // see R22
  assign LINK.status_two = word[1]; // see R22
  assign LINK.unit_err = d_reg.unit_err;
  assign READY_O = d_reg.ready;
endmodule // tsw_device

// ---- rtl/tsw_host.sv ----
// Host end: ladder logic driving control bits from user requests
`timescale 1ns/1ps
module tsw_host #(
  parameter int START_CYC = tsw_pkg::TSW_START_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Device side
  tsw_if.host LINK,
  // User requests, one bit per task, plus one unit error clear
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] AUTO_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] RUN_REQ_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] ERR_CLR_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] MRST_I,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] PAUSE_I,
  input wire logic UNIT_ERR_CLR_I,
  // Status
  output logic [tsw_pkg::TSW_NUM_TASKS-1:0] BUSY_O
);
  import tsw_pkg::*;

  typedef struct packed {
    logic [TSW_NUM_TASKS-1:0][31:0] cnt;
    logic [TSW_NUM_TASKS-1:0] start;
    logic [TSW_NUM_TASKS-1:0] pause;
  } tsw_host_t;

  tsw_host_t h_reg, h_next;
  logic [TSW_WORD_W-1:0] word [TSW_NUM_TASKS];

  assign word[0] = LINK.status_one;
  assign word[1] = LINK.status_two;

  always_comb begin
    h_next = h_reg;
    for (int t = 0; t < TSW_NUM_TASKS; t++) begin
      if (h_reg.cnt[t] != 32'h0) begin
        h_next.cnt[t] = h_reg.cnt[t] - 32'h1; // see R23
      end else if (!h_reg.start[t]) begin
        if (RUN_REQ_I[t] && word[t][TSW_BIT_AUTO]) begin
          h_next.start[t] = 1'b1; // see R06
          h_next.cnt[t] = 32'(START_CYC);
        end
      end else if (word[t][TSW_BIT_DONE] || !word[t][TSW_BIT_AUTO]) begin
        h_next.start[t] = 1'b0; // see R13
        h_next.cnt[t] = 32'(START_CYC);
      end
      // Pause held while the program still runs
      h_next.pause[t] = PAUSE_I[t] & word[t][TSW_BIT_RUN]; // see R14
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  assign LINK.auto_req = AUTO_I;
  assign LINK.cycle_start = h_reg.start;
  assign LINK.err_reset = ERR_CLR_I; // see R04
  assign LINK.mcode_reset = MRST_I; // see R17
  assign LINK.pause = h_reg.pause;
  assign LINK.unit_err_reset = UNIT_ERR_CLR_I;
  assign BUSY_O = h_reg.start;
endmodule // tsw_host

// ---- rtl/tsw_if.sv ----
// Interface joining the device status words and the host ladder logic
`timescale 1ns/1ps
interface tsw_if;
  import tsw_pkg::*;
  // Host control bits, one per task, and one unit error reset
  logic [TSW_NUM_TASKS-1:0] auto_req;
  logic [TSW_NUM_TASKS-1:0] cycle_start;
  logic [TSW_NUM_TASKS-1:0] err_reset;
  logic [TSW_NUM_TASKS-1:0] mcode_reset;
  logic [TSW_NUM_TASKS-1:0] pause;
  logic unit_err_reset;
  // Device status
  logic [TSW_WORD_W-1:0] status_one;
  logic [TSW_WORD_W-1:0] status_two;
  logic unit_err;
  modport device (
    input auto_req, cycle_start, err_reset, mcode_reset, pause,
    input unit_err_reset,
    output status_one, status_two, unit_err
  );
  modport host (
    output auto_req, cycle_start, err_reset, mcode_reset, pause,
    output unit_err_reset,
    input status_one, status_two, unit_err
  );
endinterface

// ---- rtl/tsw_pkg.sv ----
// Package of constants and types for the task status word flags
package tsw_pkg;
  // Status word positions, word index within the exchange area
  localparam logic [7:0] TSW_TASK_ONE_IDX = 8'h0B;
  localparam logic [7:0] TSW_TASK_TWO_IDX = 8'h0D;
  localparam int TSW_NUM_TASKS = 2;
  localparam int TSW_WORD_W = 16;
  // Bit positions inside a task status word
  localparam int TSW_BIT_ERR = 0;
  localparam int TSW_BIT_AUTO = 2;
  localparam int TSW_BIT_MAN = 3;
  localparam int TSW_BIT_RUN = 4;
  localparam int TSW_BIT_DONE = 5;
  localparam int TSW_BIT_OPT = 6;
  localparam int TSW_BIT_MRST = 7;
  localparam int TSW_BIT_MSTB = 8;
  localparam int TSW_BIT_START = 9;
  // M code ranges
  localparam logic [9:0] TSW_MCODE_RST_MAX = 10'h1F3;
  localparam logic [9:0] TSW_MCODE_MAX = 10'h3E7;
  localparam int TSW_MCODE_W = 10;
  // Timing
  localparam int TSW_CLK_HZ = 40_000_000;
  localparam int TSW_INIT_MS = 130;
  localparam int TSW_INIT_CYC = TSW_INIT_MS * (TSW_CLK_HZ / 1000);
  localparam int TSW_START_MS = 20;
  localparam int TSW_START_CYC = TSW_START_MS * (TSW_CLK_HZ / 1000);
  localparam logic [15:0] TSW_ZERO_WORD = 16'h0000;

  // Program sequencing state of one task
  typedef enum logic [3:0] {
    TSW_IDLE = 4'h1,
    TSW_EXEC = 4'h2,
    TSW_WAIT = 4'h4,
    TSW_STOP = 4'h8
  } tsw_run_t;
endpackage

// ---- rtl/tsw_task.sv ----
// One task status word: flags and program sequencing of a single task
`timescale 1ns/1ps
module tsw_task (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host controls
  input wire logic ready_i,
  input wire logic auto_req_i,
  input wire logic cycle_start_i,
  input wire logic err_reset_i,
  input wire logic mcode_reset_i,
  // Execution events
  input wire logic prog_err_i,
  input wire logic axis_err_i,
  input wire logic end_instr_i,
  input wire logic opt_stop_instr_i,
  input wire logic opt_move_instr_i,
  input wire logic opt_input_i,
  input wire logic mcode_valid_i,
  input wire logic [tsw_pkg::TSW_MCODE_W-1:0] mcode_i,
  input wire logic decel_stop_i,
  input wire logic axes_stopped_i,
  // Status
  output logic [tsw_pkg::TSW_WORD_W-1:0] word_o,
  output logic err_set_o
);
  import tsw_pkg::*;

  typedef struct packed {
    tsw_run_t st;
    logic err;
    logic auto_m;
    logic man_m;
    logic done;
    logic opt;
    logic opt_hi;
    logic mrst;
    logic mrst_seen;
    logic mstb;
    logic start_rx;
    logic start_d;
    logic err_pulse;
    logic run;
  } tsw_task_t;

  tsw_task_t s_reg, s_next;
  logic start_edge;
  logic fault;

  assign start_edge = cycle_start_i & ~s_reg.start_d;
  assign fault = prog_err_i | axis_err_i;

  always_comb begin
    s_next = s_reg;
    s_next.start_d = cycle_start_i;
    s_next.err_pulse = 1'b0;
    s_next.start_rx = cycle_start_i & (s_reg.start_rx | start_edge); // see R21
    // Mode indications held clear until unit ready
    s_next.auto_m = ready_i & auto_req_i; // see R06 R08
    s_next.man_m = ready_i & ~auto_req_i; // see R07 R08
    // Fault set wins over host reset
    if (err_reset_i) begin
      s_next.err = 1'b0; // see R04
    end
    if (fault && s_reg.st != TSW_IDLE) begin
      s_next.err = 1'b1; // see R01 R02
      s_next.err_pulse = 1'b1;
    end
    s_next.mstb = mcode_valid_i && mcode_i <= TSW_MCODE_MAX; // see R20
    case (s_reg.st)
      TSW_IDLE: begin
        if (start_edge && s_reg.auto_m) begin
          s_next.st = TSW_EXEC; // see R06
          s_next.done = 1'b0; // see R12
        end
      end
      TSW_EXEC: begin
        if (decel_stop_i) begin
          s_next.st = TSW_STOP; // see R10
        end else if (end_instr_i) begin
          s_next.st = TSW_IDLE; // see R11
          s_next.done = 1'b1;
        end else if (mcode_valid_i && mcode_i <= TSW_MCODE_RST_MAX) begin
          s_next.st = TSW_WAIT; // see R17 R18
          s_next.mrst = 1'b1;
          s_next.mrst_seen = 1'b0;
        end else if (opt_stop_instr_i || opt_move_instr_i) begin
          s_next.st = TSW_WAIT; // see R15 R16
          s_next.opt = 1'b1;
          s_next.opt_hi = opt_move_instr_i;
          // Stale high-seen mark from an M code wait would skip the stop
          s_next.mrst_seen = 1'b0;
        end
      end
      TSW_WAIT: begin
        if (s_reg.mrst) begin
          // Reset must be seen high and then low
          if (mcode_reset_i) begin
            s_next.mrst_seen = 1'b1;
          end else if (s_reg.mrst_seen) begin
            s_next.mrst = 1'b0; // see R17
            s_next.st = TSW_EXEC;
          end
        end else if (s_reg.opt_hi) begin
          if (opt_input_i) begin
            s_next.opt = 1'b0; // see R16
            s_next.st = TSW_EXEC;
          end
        end else if (opt_input_i) begin
          s_next.opt_hi = 1'b0;
          s_next.mrst_seen = 1'b1; // see R15
        end else if (s_reg.mrst_seen) begin
          s_next.opt = 1'b0;
          s_next.mrst_seen = 1'b0;
          s_next.st = TSW_EXEC;
        end
      end
      TSW_STOP: begin
        if (axes_stopped_i) begin
          s_next.st = TSW_IDLE; // see R10
        end
      end
      default: begin
        s_next.st = TSW_IDLE;
      end
    endcase
    // Leaving automatic mode drops state, optional stop, M reset and completed together
    if (!s_next.auto_m) begin
      s_next.st = TSW_IDLE; // see R09
      s_next.opt = 1'b0;
      s_next.mrst = 1'b0;
      s_next.done = 1'b0; // see R12
    end else if (!s_reg.auto_m && s_next.auto_m && s_reg.man_m) begin
      s_next.done = 1'b1; // see R12
    end
    // Run kept in its own flop so the word bit needs no decode
    s_next.run = (s_next.st != TSW_IDLE) | s_next.mrst; // see R10 R19
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{st: TSW_IDLE, default: 1'b0};
    end else begin
      s_reg <= s_next; // see R24
    end
  end

  always_comb begin
    word_o = TSW_ZERO_WORD;
    word_o[TSW_BIT_ERR] = s_reg.err;
    word_o[TSW_BIT_AUTO] = s_reg.auto_m;
    word_o[TSW_BIT_MAN] = s_reg.man_m;
    // Run stays set while parked on an M code reset
    word_o[TSW_BIT_RUN] = s_reg.run; // see R19
    word_o[TSW_BIT_DONE] = s_reg.done;
    word_o[TSW_BIT_OPT] = s_reg.opt;
    word_o[TSW_BIT_MRST] = s_reg.mrst;
    word_o[TSW_BIT_MSTB] = s_reg.mstb;
    word_o[TSW_BIT_START] = s_reg.start_rx;
  end
  assign err_set_o = s_reg.err_pulse;
endmodule // tsw_task

// ---- test/tb_top.sv ----
// Testbench joining host and device ends of the task status words
`timescale 1ns/1ps
module tb_top;
  import tsw_pkg::*;
  typedef struct packed {logic [9:0] code; logic mrst;} tsw_row_t;
  logic CLK_I, RST_I, uclr, ready;
  logic [1:0] auto_in, run_in, eclr, mrst_in, pause_in, perr, aerr, endi;
  logic [1:0] ostop, omove, oin, mval, decel, astop, busy;
  logic [9:0] mcode;
  int num_errors = 0;
  int num_checks = 0;
  tsw_row_t rows [4];
  tsw_if link();
  // Short counts keep the run brief
  tsw_device #(.INIT_CYC(10)) tsw_device_inst (.CLK_I(CLK_I), .RST_I(RST_I),
    .LINK(link), .PROG_ERR_I(perr), .AXIS_ERR_I(aerr), .END_INSTR_I(endi),
    .OPT_STOP_INSTR_I(ostop), .OPT_MOVE_INSTR_I(omove), .OPT_INPUT_I(oin),
    .MCODE_VALID_I(mval), .MCODE_ONE_I(mcode), .MCODE_TWO_I(mcode),
    .DECEL_STOP_I(decel), .AXES_STOPPED_I(astop), .READY_O(ready));
  tsw_host #(.START_CYC(4)) tsw_host_inst (.CLK_I(CLK_I), .RST_I(RST_I),
    .LINK(link), .AUTO_I(auto_in), .RUN_REQ_I(run_in), .ERR_CLR_I(eclr),
    .MRST_I(mrst_in), .PAUSE_I(pause_in), .UNIT_ERR_CLR_I(uclr),
    .BUSY_O(busy));
  tsw_assertions tsw_assertions_inst (.CLK_I(CLK_I), .RST_I(RST_I),
    .auto_req(link.auto_req), .cycle_start(link.cycle_start),
    .err_reset(link.err_reset), .status_one(link.status_one),
    .status_two(link.status_two), .unit_err(link.unit_err));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Both words compared, so task two is checked on every flag call
  task automatic flag(input string nm, input int b, input logic e);
    chk(nm, {15'h0000, e}, {15'h0000, link.status_one[b]});
    chk({nm, "_two"}, {15'h0000, e}, {15'h0000, link.status_two[b]});
  endtask
  task automatic wait_flag(input string nm, input int b, input logic e);
    int k;
    k = 0;
    while (link.status_one[b] !== e && k < 40) begin
      step(1);
      k++;
    end
    flag(nm, b, e);
  endtask
  task automatic pulse_ev(ref logic [1:0] s);
    s = 2'h3;
    step(1);
    s = 2'h0;
    step(1);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  initial begin
    repeat (3000) @(posedge CLK_I);
    num_errors++;
    end_sim;
  end
  initial begin
    rows = '{'{10'h000, 1'b1}, '{10'h1F3, 1'b1}, '{10'h1F4, 1'b0},
             '{10'h3E7, 1'b0}};
    {uclr, run_in, eclr, mrst_in, pause_in, perr, aerr, endi} = '0;
    {ostop, omove, oin, mval, decel, astop, mcode} = '0;
    auto_in = 2'h3;
    RST_I = 1'b1;
    step(5);
    RST_I = 1'b0;
    step(2);
    flag("auto_init", TSW_BIT_AUTO, 1'b0);
    step(12);
    chk("ready", 16'h0001, {15'h0000, ready});
    flag("auto", TSW_BIT_AUTO, 1'b1);
    flag("manual", TSW_BIT_MAN, 1'b0);
    run_in = 2'h3;
    wait_flag("run", TSW_BIT_RUN, 1'b1);
    flag("start_rx", TSW_BIT_START, 1'b1);
    flag("done_start", TSW_BIT_DONE, 1'b0);
    chk("busy", 16'h0003, {14'h0000, busy});
    for (int i = 0; i < 4; i++) begin
      mcode = rows[i].code;
      mval = 2'h3;
      step(2);
      flag("mrst", TSW_BIT_MRST, rows[i].mrst);
      flag("strobe", TSW_BIT_MSTB, 1'b1);
      flag("run_m", TSW_BIT_RUN, 1'b1);
      mval = 2'h0;
      mrst_in = {2{rows[i].mrst}};
      step(3);
      flag("mrst_hold", TSW_BIT_MRST, rows[i].mrst);
      mrst_in = 2'h0;
      step(3);
      flag("mrst_done", TSW_BIT_MRST, 1'b0);
      flag("strobe_off", TSW_BIT_MSTB, 1'b0);
    end
    pulse_ev(perr);
    flag("err_prog", TSW_BIT_ERR, 1'b1);
    chk("unit_err", 16'h0001, {15'h0000, link.unit_err});
    eclr = 2'h3;
    step(2);
    eclr = 2'h0;
    step(1);
    flag("err_clr", TSW_BIT_ERR, 1'b0);
    chk("unit_hold", 16'h0001, {15'h0000, link.unit_err});
    uclr = 1'b1;
    step(2);
    uclr = 1'b0;
    step(1);
    chk("unit_clr", 16'h0000, {15'h0000, link.unit_err});
    pulse_ev(aerr);
    flag("err_axis", TSW_BIT_ERR, 1'b1);
    chk("unit_again", 16'h0001, {15'h0000, link.unit_err});
    eclr = 2'h3;
    uclr = 1'b1;
    step(2);
    {eclr, uclr} = '0;
    pulse_ev(ostop);
    flag("opt_stop", TSW_BIT_OPT, 1'b1);
    oin = 2'h3;
    step(2);
    flag("opt_high", TSW_BIT_OPT, 1'b1);
    oin = 2'h0;
    step(2);
    flag("opt_low", TSW_BIT_OPT, 1'b0);
    pulse_ev(omove);
    flag("opt_move", TSW_BIT_OPT, 1'b1);
    oin = 2'h3;
    step(2);
    flag("opt_go", TSW_BIT_OPT, 1'b0);
    oin = 2'h0;
    pulse_ev(endi);
    flag("run_end", TSW_BIT_RUN, 1'b0);
    flag("done_end", TSW_BIT_DONE, 1'b1);
    run_in = 2'h0;
    wait_flag("start_off", TSW_BIT_START, 1'b0);
    auto_in = 2'h0;
    step(3);
    flag("man_on", TSW_BIT_MAN, 1'b1);
    flag("done_man", TSW_BIT_DONE, 1'b0);
    // Start while manual must be ignored
    run_in = 2'h3;
    step(6);
    flag("run_refused", TSW_BIT_RUN, 1'b0);
    chk("busy_man", 16'h0000, {14'h0000, busy});
    run_in = 2'h0;
    auto_in = 2'h3;
    step(10);
    flag("done_auto", TSW_BIT_DONE, 1'b1);
    // Fault standing while idle must wait for the next run
    perr = 2'h3;
    step(2);
    flag("err_idle", TSW_BIT_ERR, 1'b0);
    run_in = 2'h3;
    wait_flag("run2", TSW_BIT_RUN, 1'b1);
    pause_in = 2'h3;
    step(1);
    flag("err_rerun", TSW_BIT_ERR, 1'b1);
    perr = 2'h0;
    flag("done_rerun", TSW_BIT_DONE, 1'b0);
    step(1);
    chk("pause_run", 16'h0003, {14'h0000, link.pause});
    pulse_ev(decel);
    step(3);
    flag("run_decel", TSW_BIT_RUN, 1'b1);
    astop = 2'h3;
    step(3);
    flag("run_stopped", TSW_BIT_RUN, 1'b0);
    step(1);
    chk("pause_off", 16'h0000, {14'h0000, link.pause});
    pause_in = 2'h0;
    end_sim;
  end
endmodule // tb_top

// ---- test/tsw_assertions.sv ----
// Checker of the task status word handshakes seen on the link
`timescale 1ns/1ps
module tsw_assertions (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Link signals
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] auto_req,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] cycle_start,
  input wire logic [tsw_pkg::TSW_NUM_TASKS-1:0] err_reset,
  input wire logic [tsw_pkg::TSW_WORD_W-1:0] status_one,
  input wire logic [tsw_pkg::TSW_WORD_W-1:0] status_two,
  input wire logic unit_err
);
  import tsw_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence start_drop_s;
    $fell(cycle_start[0]);
  endsequence
  sequence start_clear_s;
    ##1 !status_one[TSW_BIT_START];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  task_err_unit_a: assert property (
    $rose(status_one[TSW_BIT_ERR]) |-> ##[0:1] unit_err)
    else $error("unit error not raised with task error");
  err_held_a: assert property (
    status_one[TSW_BIT_ERR] && !err_reset[0] |=> status_one[TSW_BIT_ERR])
    else $error("task error dropped without reset");
  mode_excl_a: assert property (
    !(status_one[TSW_BIT_AUTO] && status_one[TSW_BIT_MAN]))
    else $error("both mode flags set");
  auto_follow_a: assert property (
    $rose(status_one[TSW_BIT_AUTO]) |-> $past(auto_req[0]))
    else $error("automatic flag rose without request");
  run_needs_auto_a: assert property (
    $rose(status_one[TSW_BIT_RUN]) |-> status_one[TSW_BIT_AUTO])
    else $error("run began outside automatic mode");
  manual_clear_a: assert property (
    $rose(status_one[TSW_BIT_MAN]) |-> status_one[7:4] == 4'h0)
    else $error("run flags left set in manual mode");
  done_run_a: assert property (
    $rose(status_one[TSW_BIT_DONE]) |-> !status_one[TSW_BIT_RUN])
    else $error("completed set while run still set");
  mrst_run_a: assert property (
    status_one[TSW_BIT_MRST] |-> status_one[TSW_BIT_RUN])
    else $error("M reset wait without run flag");
  mrst_two_a: assert property (
    status_two[TSW_BIT_MRST] |-> status_two[TSW_BIT_RUN])
    else $error("task two M reset wait without run flag");
  start_set_a: assert property (
    $rose(status_one[TSW_BIT_START]) |-> $past(cycle_start[0]))
    else $error("start received without start control");
  start_clear_a: assert property (
    start_drop_s |-> start_clear_s)
    else $error("start received held after start low");
endmodule // tsw_assertions
